// File: rtl/icw_pkg.sv
// Package of constants for the interrupt and comparator wake block.
// Assumes a 32-bit APB register bus and one 125 MHz clock.
package icw_pkg;
  // APB register byte offsets.
  localparam logic [7:0] ADDR_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_WAKE    = 8'h08;
  localparam logic [7:0] ADDR_CMPCTL  = 8'h0C;
  localparam logic [7:0] ADDR_WDEN    = 8'h10;
  localparam logic [7:0] ADDR_P6LATCH = 8'h14;
  localparam logic [7:0] ADDR_CORE    = 8'h18;
  localparam logic [7:0] ADDR_SHADOW  = 8'h1C;
  // Source bit positions in the flag and mask registers.
  localparam int SRC_TMR  = 0;
  localparam int SRC_P6   = 1;
  localparam int SRC_EX0  = 2;
  localparam int SRC_EX1  = 3;
  localparam int SRC_CMP  = 4;
  localparam int NSRC     = 5;
  // Wake-up control fields.
  localparam int WK_CMPF  = 0;
  localparam int WK_CMP_WAKE_EN = 2;
  localparam int WK_P6WE  = 4;
  localparam int WK_EX1F  = 7;
  // Comparator control fields.
  localparam int CC_SEL_LO = 3;
  localparam int CC_SEL_HI = 4;
  localparam int CC_RES    = 5;
  localparam int CC_EX0SEL = 6;
  localparam int CC_EX1SEL = 7;
  // Watchdog and enable register fields.
  localparam int WD_CMP_IRQ_EN  = 0;
  localparam logic [7:0] WD_MASK = 8'hBD;
  // Comparator select codes.
  localparam logic [1:0] CSEL_OFF = 2'h0;
  localparam logic [1:0] CSEL_IN  = 2'h1;
  localparam logic [1:0] CSEL_OUT = 2'h2;
  localparam logic [1:0] CSEL_AMP = 2'h3;
  // Interrupt vector address.
  localparam logic [11:0] IRQ_VECTOR = 12'h008;
  // Noise filter: pulses under 8 system clock periods are rejected.
  localparam int FILT_PERIODS = 8;
  localparam int CLK_MHZ      = 125;
  localparam int FILT_CYCLES  = FILT_PERIODS;
  localparam logic [3:0] FILT_MAX = 4'(FILT_CYCLES - 1);
endpackage

// File: rtl/icw_filt_if.sv
// Interface bundling one external interrupt pin and its filtered edge.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/100ps
interface icw_filt_if;
  logic pin;
  logic edge_sel;
  logic evt;
  modport filt (input pin, input edge_sel, output evt);
  modport user (output pin, output edge_sel, input evt);
endinterface

// File: rtl/icw_filt.sv
// Digital noise filter and edge detector for one external interrupt pin.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/100ps
module icw_filt (
  input wire logic    pclk,
  input wire logic    presetn,
  icw_filt_if.filt    fi
);
  logic [3:0] cnt_reg;
  logic       stable_reg;
  logic       differs;
  logic       accept;

  // The candidate level must hold for the full filter span to be accepted.
  assign differs = (fi.pin != stable_reg);
  assign accept  = differs && (cnt_reg == icw_pkg::FILT_MAX);

  // Count cycles of a differing level, restart whenever it drops back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg    <= 4'h0;
      stable_reg <= 1'b0;
    end else if (!differs || accept) begin
      cnt_reg <= 4'h0;
      if (accept) begin
        stable_reg <= fi.pin;
      end
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // Edge select: 0 picks falling edges, 1 picks rising edges.
  assign fi.evt = accept && (fi.pin == fi.edge_sel);

  AST_FILT_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
    fi.evt |-> $past(fi.pin, 7) == fi.pin)
    else $error("Filter passed a pulse shorter than the span.");
endmodule

// File: rtl/icw_top.sv
// Interrupt controller with comparator and port change wake-up, APB slave.
// Assumes synchronous pins and a core that reports instruction boundaries.
`timescale 1ns/100ps
module icw_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_counter_ovf,
  input  wire logic [7:0]  port6_in,
  input  wire logic        port6_read,
  input  wire logic        ext_irq0,
  input  wire logic        ext_irq1,
  input  wire logic        cmp_raw,
  input  wire logic        cmp_result_read,
  input  wire logic        instr_boundary,
  input  wire logic        enable_irq_instr,
  input  wire logic        disable_irq_instr,
  input  wire logic        return_irq_instr,
  input  wire logic        sleep_instr,
  input  wire logic [7:0]  core_acc,
  input  wire logic [3:0]  core_status,
  input  wire logic [2:0]  core_page,
  input  wire logic [7:0]  core_ptr,
  output logic             irq_take,
  output logic [11:0]      vector_addr,
  output logic             core_sleeping,
  output logic             wake_pulse,
  output logic             restore_valid,
  output logic [22:0]      restore_data,
  output logic             cmp_enable,
  output logic             cmp_amp_mode,
  output logic             cmp_in_pins_en,
  output logic             cmp_out_pin,
  output logic             cmp_out_pin_oe
);
  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  typedef enum logic [1:0] {
    ICW_RUN   = 2'b01,
    ICW_SLEEP = 2'b10
  } icw_state_t;

  icw_state_t              state_reg;
  icw_state_t              state_next;
  logic [icw_pkg::NSRC-1:0] flag_reg;
  logic [icw_pkg::NSRC-1:0] mask_reg;
  logic [icw_pkg::NSRC-1:0] evt;
  logic [icw_pkg::NSRC-1:0] clr;
  logic [7:0]  wake_reg;
  logic [7:0]  cmpctl_reg;
  logic [7:0]  wden_reg;
  logic [7:0]  p6_ref_reg;
  logic        cmp_latch_reg;
  logic        gie_reg;
  logic        in_isr_reg;
  logic [22:0] shadow_reg;
  logic [7:0]  prdata_next;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [7:0]  wdat;
  logic        p6_change;
  logic        cmp_change;
  logic        pending;
  logic        wake_any;
  logic [1:0]  cmp_sel;
  logic        ex0_evt;
  logic        ex1_evt;
  localparam int NSRC_W = icw_pkg::NSRC;
  logic [NSRC_W-1:0] pend_vec;

  icw_filt_if fif0 ();
  icw_filt_if fif1 ();

  // Zero-wait APB slave; writes and reads act in the access cycle.
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign wdat    = pwdata[7:0];
  assign addr_ok = (paddr == icw_pkg::ADDR_FLAGS) || (paddr == icw_pkg::ADDR_MASK) ||
                   (paddr == icw_pkg::ADDR_WAKE) || (paddr == icw_pkg::ADDR_CMPCTL) ||
                   (paddr == icw_pkg::ADDR_WDEN) || (paddr == icw_pkg::ADDR_P6LATCH) ||
                   (paddr == icw_pkg::ADDR_CORE) || (paddr == icw_pkg::ADDR_SHADOW);
  assign pslverr = psel && penable && !addr_ok;

  // ****************************************************************
  // Event sources
  // ****************************************************************
  assign fif0.pin      = ext_irq0;
  assign fif0.edge_sel = cmpctl_reg[icw_pkg::CC_EX0SEL];
  assign fif1.pin      = ext_irq1;
  assign fif1.edge_sel = cmpctl_reg[icw_pkg::CC_EX1SEL];
  assign ex0_evt       = fif0.evt;
  assign ex1_evt       = fif1.evt;

  icw_filt u_filt0 (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (fif0)
  );

  icw_filt u_filt1 (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (fif1)
  );

  // Port-6 and comparator changes are mismatches against software-read latches.
  assign cmp_sel    = {cmpctl_reg[icw_pkg::CC_SEL_HI], cmpctl_reg[icw_pkg::CC_SEL_LO]};
  assign cmp_enable = (cmp_sel != icw_pkg::CSEL_OFF);
  assign p6_change  = (port6_in != p6_ref_reg);
  assign cmp_change = cmp_enable && (cmp_raw != cmp_latch_reg);

  // Flags only record events whose mask bit is enabled, global enable aside.
  assign evt[icw_pkg::SRC_TMR] = timer_counter_ovf;
  assign evt[icw_pkg::SRC_P6]  = p6_change;
  assign evt[icw_pkg::SRC_EX0] = ex0_evt;
  assign evt[icw_pkg::SRC_EX1] = ex1_evt;
  assign evt[icw_pkg::SRC_CMP] = cmp_change && wake_reg[icw_pkg::WK_CMP_WAKE_EN];

  // Software clears flags by writing a one to the flag register bit.
  assign clr = (wr_en && paddr == icw_pkg::ADDR_FLAGS) ? wdat[NSRC_W-1:0] : '0;

  // Flags: set wins over a clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < NSRC_W; gi = gi + 1) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_reg[gi] <= 1'b0;
        end else if (evt[gi] && mask_reg[gi]) begin
          flag_reg[gi] <= 1'b1;
        end else if (clr[gi]) begin
          flag_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Comparator interrupt also needs the watchdog-register enable bit.
  assign pend_vec = flag_reg & mask_reg &
                    {wden_reg[icw_pkg::WD_CMP_IRQ_EN], {(NSRC_W-1){1'b1}}};
  assign pending  = |pend_vec;

  // Wake sources: port change with its enable, comparator with its enable, timer and both external pins.
  assign wake_any = (pend_vec[icw_pkg::SRC_P6] && wake_reg[icw_pkg::WK_P6WE]) ||
                    pend_vec[icw_pkg::SRC_CMP] ||
                    pend_vec[icw_pkg::SRC_TMR] || pend_vec[icw_pkg::SRC_EX0] ||
                    pend_vec[icw_pkg::SRC_EX1];

  // ****************************************************************
  // Sleep and interrupt entry
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ICW_RUN: begin
        if (sleep_instr) begin
          state_next = ICW_SLEEP;
        end
      end
      ICW_SLEEP: begin
        if (wake_any) begin
          state_next = ICW_RUN;
        end
      end
      default: state_next = ICW_RUN;
    endcase
  end

  assign core_sleeping = (state_reg == ICW_SLEEP);
  assign wake_pulse    = core_sleeping && wake_any;
  // Taken only at a boundary while running; after wake with enable off, no branch.
  assign irq_take      = (state_reg == ICW_RUN) && instr_boundary && gie_reg && pending;
  assign vector_addr   = icw_pkg::IRQ_VECTOR;
  assign restore_valid = return_irq_instr && in_isr_reg;
  assign restore_data  = shadow_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ICW_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Global enable: entry clears it, return and enable set it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_reg    <= 1'b0;
      in_isr_reg <= 1'b0;
    end else if (irq_take) begin
      gie_reg    <= 1'b0;
      in_isr_reg <= 1'b1;
    end else if (return_irq_instr) begin
      gie_reg    <= 1'b1;
      in_isr_reg <= 1'b0;
    end else if (enable_irq_instr) begin
      gie_reg <= 1'b1;
    end else if (disable_irq_instr) begin
      gie_reg <= 1'b0;
    end
  end

  // Shadow stack captures core context on entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_reg <= 23'h000000;
    end else if (irq_take) begin
      shadow_reg <= {core_acc, core_status, core_page, core_ptr};
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg   <= '0;
      wden_reg   <= 8'h00;
      cmpctl_reg <= 8'h00;
    end else if (wr_en) begin
      if (paddr == icw_pkg::ADDR_MASK) begin
        mask_reg <= wdat[NSRC_W-1:0];
      end
      if (paddr == icw_pkg::ADDR_WDEN) begin
        wden_reg <= wdat & icw_pkg::WD_MASK;
      end
      if (paddr == icw_pkg::ADDR_CMPCTL) begin
        cmpctl_reg <= wdat & 8'hD8;
      end
    end
  end

  // Wake enables are plain bits; bit 7 reads the masked interrupt-one flag, bit 0 the unmasked comparator flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 8'h00;
    end else if (wr_en && paddr == icw_pkg::ADDR_WAKE) begin
      wake_reg <= wdat & 8'h14;
    end
  end

  // Reference latches: a read of port 6 or the comparator result loads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p6_ref_reg    <= 8'h00;
      cmp_latch_reg <= 1'b0;
    end else begin
      if (port6_read || (rd_en && paddr == icw_pkg::ADDR_P6LATCH)) begin
        p6_ref_reg <= port6_in;
      end
      if (cmp_result_read || (rd_en && paddr == icw_pkg::ADDR_CMPCTL)) begin
        cmp_latch_reg <= cmp_raw;
      end
    end
  end

  // Read mux.
  always_comb begin
    prdata_next = 8'h00;
    unique case (paddr)
      icw_pkg::ADDR_FLAGS:   prdata_next = {3'h0, flag_reg & mask_reg};
      icw_pkg::ADDR_MASK:    prdata_next = {3'h0, mask_reg};
      icw_pkg::ADDR_WAKE:    prdata_next = {pend_vec[icw_pkg::SRC_EX1], 2'h0, wake_reg[icw_pkg::WK_P6WE], 1'b0,
                                            wake_reg[icw_pkg::WK_CMP_WAKE_EN], 1'b0, flag_reg[icw_pkg::SRC_CMP]};
      icw_pkg::ADDR_CMPCTL:  prdata_next = {cmpctl_reg[7:6], cmp_raw, cmpctl_reg[4:3], 3'h0};
      icw_pkg::ADDR_WDEN:    prdata_next = wden_reg;
      icw_pkg::ADDR_P6LATCH: prdata_next = port6_in;
      icw_pkg::ADDR_CORE:    prdata_next = {5'h00, in_isr_reg, core_sleeping, gie_reg};
      icw_pkg::ADDR_SHADOW:  prdata_next = shadow_reg[22:15];
      default:               prdata_next = 8'h00;
    endcase
  end
  assign prdata = {24'h000000, prdata_next};

  // ****************************************************************
  // Comparator pin functions
  // ****************************************************************
  // Shared pin: interrupt one wins, then comparator output, then plain I/O.
  assign cmp_in_pins_en = cmp_enable;
  assign cmp_amp_mode   = (cmp_sel == icw_pkg::CSEL_AMP);
  assign cmp_out_pin_oe = !cmpctl_reg[icw_pkg::CC_EX1SEL] &&
                          ((cmp_sel == icw_pkg::CSEL_OUT) || (cmp_sel == icw_pkg::CSEL_AMP));
  assign cmp_out_pin    = cmp_out_pin_oe && cmp_raw;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
    irq_take |-> vector_addr == 12'h008)
    else $error("Vector address not 008H.");
  AST_GIE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    irq_take |=> !gie_reg)
    else $error("Global enable left on after entry.");
  AST_RETURN_IRQ_INSTR: assert property (@(posedge pclk) disable iff (!presetn)
    (return_irq_instr && !irq_take) |=> gie_reg)
    else $error("Return did not set global enable.");
  AST_NO_TAKE: assert property (@(posedge pclk) disable iff (!presetn)
    irq_take |-> gie_reg && pending && instr_boundary)
    else $error("Interrupt taken without cause.");
  AST_CMP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_change && wake_reg[icw_pkg::WK_CMP_WAKE_EN] && mask_reg[icw_pkg::SRC_CMP]) |=> flag_reg[icw_pkg::SRC_CMP])
    else $error("Comparator change not flagged.");
  AST_CMP_IRQ_EN: assert property (@(posedge pclk) disable iff (!presetn)
    !wden_reg[icw_pkg::WD_CMP_IRQ_EN] |-> !pend_vec[icw_pkg::SRC_CMP])
    else $error("Comparator interrupt without enable.");
  AST_SHADOW: assert property (@(posedge pclk) disable iff (!presetn)
    irq_take |=> shadow_reg == $past({core_acc, core_status, core_page, core_ptr}))
    else $error("Context not saved on entry.");
  AST_PIN_PRIO: assert property (@(posedge pclk) disable iff (!presetn)
    cmpctl_reg[icw_pkg::CC_EX1SEL] |-> !cmp_out_pin_oe)
    else $error("Comparator drove pin owned by interrupt one.");
  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (core_sleeping && wake_any) |=> !core_sleeping)
    else $error("Wake source did not end sleep.");
  AST_P6_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (p6_change && mask_reg[icw_pkg::SRC_P6]) |=> flag_reg[icw_pkg::SRC_P6])
    else $error("Port change not flagged.");

  COV_TAKE: cover property (@(posedge pclk) disable iff (!presetn) irq_take);
  COV_WAKE: cover property (@(posedge pclk) disable iff (!presetn) wake_pulse);
  COV_RETURN_IRQ_INSTR: cover property (@(posedge pclk) disable iff (!presetn) restore_valid);
  COV_CMP:  cover property (@(posedge pclk) disable iff (!presetn) cmp_change ##1 flag_reg[icw_pkg::SRC_CMP]);
endmodule

// File: test/icw_pins_model.sv
// Partner model of the pins and comparator that surround the interrupt block.
// Assumes it shares pclk with the bench and that the bench calls its tasks.
`timescale 1ns/100ps
module icw_pins_model (
  input  wire logic       pclk,
  output logic            ext_irq0,
  output logic            ext_irq1,
  output logic [7:0]      port6_in,
  output logic            cmp_raw
);
  // ****************************************
  // Pin drivers
  // ****************************************
  logic [1:0] ext = 2'h0;
  // Both external pins idle low between pulses.
  assign ext_irq0 = ext[0];
  assign ext_irq1 = ext[1];
  // Port and comparator levels start low.
  initial begin
    port6_in = 8'h00;
    cmp_raw  = 1'h0;
  end
  // Holds one external pin high for n clocks, short enough to be noise when n is under 8.
  task automatic ext_pulse(input int p, input int n);
    @(posedge pclk);
    ext[p] <= 1'h1;
    repeat (n) @(posedge pclk);
    ext[p] <= 1'h0;
  endtask
  // Moves the port pins to a new level.
  task automatic set_port6(input logic [7:0] v);
    @(posedge pclk);
    port6_in <= v;
  endtask
  // Moves the comparator output to a new level.
  task automatic set_cmp(input logic v);
    @(posedge pclk);
    cmp_raw <= v;
  endtask
endmodule

// File: test/icw_top_tb.sv
// Self-checking bench for the interrupt and comparator wake block.
// Assumes icw_pins_model drives the pins and this module is the APB master.
`timescale 1ns/100ps
module icw_top_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ctl = 8'h00;
  logic [22:0] ctx = 23'h0;
  logic [22:0] old_ctx;
  logic [31:0] prdata;
  logic        pready, pslverr, irq_take, core_sleeping, wake_pulse, restore_valid;
  logic [11:0] vector_addr;
  logic [22:0] restore_data;
  logic        cmp_enable, cmp_amp_mode, cmp_in_pins_en, cmp_out_pin, cmp_out_pin_oe;
  logic        ext_irq0, ext_irq1, cmp_raw;
  logic [7:0]  port6_in;
  logic [36:0] snap;
  logic [32:0] q[$];
  logic [31:0] lfsr = 32'hBC44DD95;
  logic [4:0]  pin_tab[5] = '{5'h00, 5'h14, 5'h17, 5'h1F, 5'h14};
  int          fail_count = 0;
  int          checks = 0;
  icw_pins_model pins (.pclk(pclk), .ext_irq0(ext_irq0), .ext_irq1(ext_irq1), .port6_in(port6_in),
    .cmp_raw(cmp_raw));
  icw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_counter_ovf(ctl[0]), .port6_in(port6_in), .port6_read(ctl[1]), .ext_irq0(ext_irq0),
    .ext_irq1(ext_irq1), .cmp_raw(cmp_raw), .cmp_result_read(ctl[2]), .instr_boundary(ctl[3]),
    .enable_irq_instr(ctl[4]), .disable_irq_instr(ctl[5]), .return_irq_instr(ctl[6]),
    .sleep_instr(ctl[7]), .core_acc(ctx[22:15]), .core_status(ctx[14:11]), .core_page(ctx[10:8]),
    .core_ptr(ctx[7:0]), .irq_take(irq_take), .vector_addr(vector_addr), .core_sleeping(core_sleeping),
    .wake_pulse(wake_pulse), .restore_valid(restore_valid), .restore_data(restore_data),
    .cmp_enable(cmp_enable), .cmp_amp_mode(cmp_amp_mode), .cmp_in_pins_en(cmp_in_pins_en),
    .cmp_out_pin(cmp_out_pin), .cmp_out_pin_oe(cmp_out_pin_oe));
  // The clock toggles every 4 ns, half of its 8 ns period.
  always #4 pclk = ~pclk;
  // ****************************************
  // Helpers
  // ****************************************
  // Steps the pseudo-random source.
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [32:0] act, input logic [32:0] exp);
    checks++;
    if (act !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  // One APB transfer; a read leaves its expected {pslverr, data} in the queue.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'h0, a, 32'h0, e);
  endtask
  // Raises one core strobe for a cycle and snapshots the core-side outputs it causes.
  task automatic pulse(input int b);
    @(posedge pclk);
    ctl[b] <= 1'h1;
    @(posedge pclk);
    snap = {irq_take, vector_addr, restore_valid, restore_data};
    ctl[b] <= 1'h0;
  endtask
  // Waits a bounded time for the wake strobe.
  task automatic wake_wait;
    for (int i = 0; i < 20 && wake_pulse !== 1'h1; i++) @(posedge pclk);
    chk(wake_pulse, 1'h1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Takes the oldest note whenever a read completes and compares it.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && q.size() > 0) begin
      chk({pslverr, prdata}, q.pop_front());
    end
  end
  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    report_and_stop();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  // Resets, then walks registers, interrupts, filters, comparator and sleep.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 33'h0);
    rd(8'h20, 33'h100000000);
    lfsr = nxt(lfsr);
    wr(icw_pkg::ADDR_MASK, {27'h0, lfsr[4:0]});
    rd(icw_pkg::ADDR_MASK, {28'h0, lfsr[4:0]});
    wr(icw_pkg::ADDR_WDEN, lfsr);
    rd(icw_pkg::ADDR_WDEN, {25'h0, lfsr[7:0] & icw_pkg::WD_MASK});
    wr(icw_pkg::ADDR_MASK, 32'h0);
    pulse(0);
    rd(icw_pkg::ADDR_FLAGS, 33'h0);
    wr(icw_pkg::ADDR_FLAGS, 32'h1F);
    wr(icw_pkg::ADDR_MASK, 32'h01);
    pulse(0);
    rd(icw_pkg::ADDR_FLAGS, 33'h01);
    ctx <= lfsr[30:8];
    pulse(4);
    pulse(0);
    pulse(3);
    chk(snap[36:24], {1'h1, icw_pkg::IRQ_VECTOR});
    rd(icw_pkg::ADDR_CORE, 33'h04);
    rd(icw_pkg::ADDR_SHADOW, {25'h0, ctx[22:15]});
    old_ctx = ctx;
    ctx <= ~ctx;
    wr(icw_pkg::ADDR_FLAGS, 32'h01);
    pulse(6);
    chk(snap[23:0], {1'h1, old_ctx});
    rd(icw_pkg::ADDR_CORE, 33'h01);
    pulse(5);
    pulse(0);
    pulse(3);
    chk(snap[36], 1'h0);
    rd(icw_pkg::ADDR_FLAGS, 33'h01);
    wr(icw_pkg::ADDR_FLAGS, 32'h01);
    wr(icw_pkg::ADDR_MASK, 32'h0C);
    for (int k = 0; k < 4; k++) begin
      wr(icw_pkg::ADDR_CMPCTL, 32'((k / 2) << (6 + k % 2)));
      pins.ext_pulse(k % 2, 7);
      repeat (12) @(posedge pclk);
      rd(icw_pkg::ADDR_FLAGS, 33'h0);
      pins.ext_pulse(k % 2, 9);
      rd(icw_pkg::ADDR_FLAGS, 33'((k / 2) * (4 << (k % 2))));
      repeat (12) @(posedge pclk);
      rd(icw_pkg::ADDR_FLAGS, 33'(4 << (k % 2)));
      wr(icw_pkg::ADDR_FLAGS, 32'h0C);
    end
    wr(icw_pkg::ADDR_MASK, 32'h10);
    wr(icw_pkg::ADDR_WAKE, 32'h04);
    wr(icw_pkg::ADDR_WDEN, 32'h01);
    wr(icw_pkg::ADDR_CMPCTL, 32'h10);
    pulse(2);
    pins.set_cmp(1'h1);
    repeat (4) @(posedge pclk);
    rd(icw_pkg::ADDR_WAKE, 33'h05);
    rd(icw_pkg::ADDR_FLAGS, 33'h10);
    rd(icw_pkg::ADDR_CMPCTL, 33'h30);
    wr(icw_pkg::ADDR_FLAGS, 32'h10);
    rd(icw_pkg::ADDR_WAKE, 33'h04);
    pulse(7);
    pins.set_cmp(1'h0);
    wake_wait();
    rd(icw_pkg::ADDR_CMPCTL, 33'h10);
    wr(icw_pkg::ADDR_FLAGS, 32'h10);
    // A high comparator level makes the shared pin's data visible whenever it is driven.
    pins.set_cmp(1'h1);
    for (int s = 0; s < 5; s++) begin
      wr(icw_pkg::ADDR_CMPCTL, (s == 4) ? 32'h90 : 32'(s << 3));
      @(posedge pclk);
      chk({cmp_enable, cmp_amp_mode, cmp_in_pins_en, cmp_out_pin_oe, cmp_out_pin}, pin_tab[s]);
    end
    wr(icw_pkg::ADDR_CMPCTL, 32'h0);
    pulse(1);
    wr(icw_pkg::ADDR_MASK, 32'h02);
    wr(icw_pkg::ADDR_WAKE, 32'h10);
    pulse(7);
    @(posedge pclk);
    chk(core_sleeping, 1'h1);
    pins.set_port6(lfsr[7:0] | 8'h01);
    wake_wait();
    repeat (2) @(posedge pclk);
    chk(core_sleeping, 1'h0);
    pulse(3);
    chk(snap[36], 1'h0);
    pulse(4);
    pulse(3);
    chk(snap[36:24], {1'h1, icw_pkg::IRQ_VECTOR});
    report_and_stop();
  end
endmodule
